// ===== shared/srh_params.svh
// Purpose: constants of the serial read command handler
// Assumes: one logical byte travels as two ascii hex characters
// Notes: offsets are byte addresses in system memory
`ifndef SRH_PARAMS_SVH
`define SRH_PARAMS_SVH

// ==========================================
// frame characters and fields
`define SRH_CHAR_START 8'h21
`define SRH_CHAR_ACK 8'h41
`define SRH_CHAR_ERR 8'h45
`define SRH_CHAR_READ 8'h52
`define SRH_CMD_MEM 8'h6D
`define SRH_CMD_CFG 8'h63
`define SRH_CMD_VER 8'h76
`define SRH_CMD_COUNT 8'h09
`define SRH_CMD_LAST_IDX 4'h9
`define SRH_CMD_CKSM_IDX 4'h8
`define SRH_RESP_EXTRA 8'h02
`define SRH_ERR_COUNT 8'h02
`define SRH_ERR_CKSM 16'hFFB8
`define SRH_CKSM_BASE 16'hFFFF

// ==========================================
// system memory map
`define SRH_CFG_BASE 16'h0010
`define SRH_VER_BASE 16'h0080
`define SRH_REG_CALIBRATION_ZERO 16'h0000
`define SRH_REG_NODE_BUS_ADDRESS 16'h002C
`define SRH_REG_SERIAL_LINK_TYPE 16'h002D
`define SRH_REG_PEAK_TEMPERATURE_RECORD 16'h002E
`define SRH_REG_UNIT_SERIAL_NUMBER 16'h004E
`define SRH_REG_FLUID_DESCRIPTOR_TEXT 16'h0056
`define SRH_REG_BOARD_REVISION 16'h007B
`define SRH_REG_FIELDBUS_SEND_TRIGGER 16'h00A4
`define SRH_REG_FIELDBUS_SEND_INTERVAL 16'h00A5
`define SRH_REG_FIELDBUS_MESSAGE_MAPPING 16'h00A7
`define SRH_REG_SMOOTHING_TIME_CONSTANT 16'h00EF
`define SRH_REG_SERIAL_LINE_SPEED 16'h00F0
`define SRH_REG_FIELDBUS_LINE_SPEED 16'h00F1
`define SRH_NODE_ADDR_RST 8'h01

// ==========================================
// timing
`define SRH_IDLE_TIMEOUT_MS 1000
`define SRH_CLK_MHZ 250

`endif

// ===== shared/srh_pkg.sv
// Purpose: types of the serial read command handler
// Assumes: nothing
// Notes: constants live in srh_params.svh
package srh_pkg;
  typedef logic [7:0] srh_byte_t;
  typedef enum {SRH_RX, SRH_LOAD, SRH_WAIT, SRH_HI, SRH_LO} srh_state_t;
  typedef enum {SRH_F_HDR, SRH_F_CNT, SRH_F_DATA, SRH_F_CKH, SRH_F_CKL} srh_field_t;
endpackage

// ===== shared/srh_mem_if.sv
// Purpose: port between the handler and its system memory
// Assumes: read data one clock after rd_en
// Notes: single write port for the instrument's own firmware
interface srh_mem_if #(parameter int AW = 8);
  logic rd_en;
  logic [AW-1:0] rd_addr;
  logic [7:0] rd_data;
  logic wr_en;
  logic [AW-1:0] wr_addr;
  logic [7:0] wr_data;
  modport ctrl(output rd_en, rd_addr, wr_en, wr_addr, wr_data, input rd_data);
  modport mem(input rd_en, rd_addr, wr_en, wr_addr, wr_data, output rd_data);
endinterface

// ===== hdl/srh_sysmem.sv
// Purpose: system memory of the instrument
// Assumes: contents undefined until firmware writes them
// Notes: registered read data, one clock latency
module srh_sysmem
  import srh_pkg::*;
#(
  parameter int AW = 8
)
(
  input wire logic clk,
  srh_mem_if.mem port
);
  logic [7:0] ram [2**AW];

  // ==========================================
  // storage
  always_ff @(posedge clk)
  begin
    if (port.wr_en)
    begin
      ram[port.wr_addr] <= port.wr_data;
    end
    if (port.rd_en)
    begin
      port.rd_data <= ram[port.rd_addr];
    end
  end
endmodule

// ===== hdl/srh_top.sv
// Purpose: serial read command interpreter (memory, settings, version)
// Assumes: rx_char/rx_valid come from a uart on this clock
// Notes: characters arriving until the answer's last char is buffered are dropped; ones arriving while the buffer drains are received
`include "srh_params.svh"
module srh_top
  import srh_pkg::*;
#(
  parameter int MEM_AW = 8,
  parameter int unsigned IDLE_CYCLES = `SRH_IDLE_TIMEOUT_MS * `SRH_CLK_MHZ * 1000
)
(
  input wire logic clk,
  input wire logic reset,
  input wire logic [7:0] rx_char,
  input wire logic rx_valid,
  output logic [7:0] tx_char,
  output logic tx_valid,
  input wire logic tx_ready,
  input wire logic fw_wr_en,
  input wire logic [15:0] fw_wr_addr,
  input wire logic [7:0] fw_wr_data,
  output logic [7:0] own_address,
  output logic busy
);
  // ==========================================
  // helpers
  function automatic logic [4:0] hex_to_nib(input logic [7:0] c);
    logic [4:0] r;
    r = 5'h00;
    if (c >= 8'h30 && c <= 8'h39)
    begin
      r = {1'b1, c[3:0]};
    end
    else if (c >= 8'h41 && c <= 8'h46)
    begin
      r = {1'b1, c[3:0] + 4'h9};
    end
    else if (c >= 8'h61 && c <= 8'h66)
    begin
      r = {1'b1, c[3:0] + 4'h9};
    end
    return r;
  endfunction

  function automatic logic [7:0] nib_to_hex(input logic [3:0] n);
    logic [7:0] r;
    r = (n < 4'hA) ? {4'h3, n} : {4'h4, n - 4'h9};
    return r;
  endfunction

  function automatic logic [15:0] cmd_base(input logic [7:0] c);
    logic [15:0] r;
    r = 16'h0000;
    if (c == `SRH_CMD_CFG)
    begin
      r = `SRH_CFG_BASE;
    end
    else if (c == `SRH_CMD_VER)
    begin
      r = `SRH_VER_BASE;
    end
    return r;
  endfunction

  localparam logic [16:0] MEM_DEPTH = 17'(2**MEM_AW);

  // ==========================================
  // memory
  srh_mem_if #(.AW(MEM_AW)) mem_bus();

  srh_sysmem #(.AW(MEM_AW)) u_mem (
    .clk(clk),
    .port(mem_bus)
  );

  // ==========================================
  // state
  srh_state_t state, next_state;
  srh_field_t field, next_field;
  logic [3:0] rx_idx, next_rx_idx;
  logic rx_hi, next_rx_hi;
  logic [3:0] rx_nib, next_rx_nib;
  srh_byte_t cnt_b, next_cnt_b;
  srh_byte_t iaddr_b, next_iaddr_b;
  srh_byte_t cmd1_b, next_cmd1_b;
  srh_byte_t cmd2_b, next_cmd2_b;
  logic [15:0] addr_b, next_addr_b;
  srh_byte_t len_b, next_len_b;
  srh_byte_t ckh_b, next_ckh_b;
  logic [15:0] rx_sum, next_rx_sum;
  logic [31:0] idle_cnt, next_idle_cnt;
  srh_byte_t cur, next_cur;
  logic [15:0] tx_sum, next_tx_sum;
  srh_byte_t remain, next_remain;
  logic [MEM_AW-1:0] rd_ptr, next_rd_ptr;
  logic is_err, next_is_err;
  logic last, next_last;
  srh_byte_t node_addr, next_node_addr;
  logic next_busy;
  srh_byte_t b0, b1, next_b0, next_b1;
  logic v0, v1, next_v0, next_v1;

  logic push;
  srh_byte_t push_data;
  logic buf_in_ready;
  logic [4:0] dec;
  srh_byte_t byte_in;
  logic [15:0] ck_rx;
  logic frame_ok;
  logic [16:0] eff;

  assign buf_in_ready = !v1;
  assign tx_char = b0;
  assign tx_valid = v0;
  assign own_address = node_addr;

  // ==========================================
  // interpreter
  always_comb
  begin
    next_state = state;
    next_field = field;
    next_rx_idx = rx_idx;
    next_rx_hi = rx_hi;
    next_rx_nib = rx_nib;
    next_cnt_b = cnt_b;
    next_iaddr_b = iaddr_b;
    next_cmd1_b = cmd1_b;
    next_cmd2_b = cmd2_b;
    next_addr_b = addr_b;
    next_len_b = len_b;
    next_ckh_b = ckh_b;
    next_rx_sum = rx_sum;
    next_idle_cnt = idle_cnt;
    next_cur = cur;
    next_tx_sum = tx_sum;
    next_remain = remain;
    next_rd_ptr = rd_ptr;
    next_is_err = is_err;
    next_last = last;
    next_node_addr = node_addr;
    push = 1'b0;
    push_data = 8'h00;
    mem_bus.rd_en = 1'b0;
    mem_bus.rd_addr = rd_ptr;
    mem_bus.wr_en = fw_wr_en && ({1'b0, fw_wr_addr} < MEM_DEPTH);
    mem_bus.wr_addr = fw_wr_addr[MEM_AW-1:0];
    mem_bus.wr_data = fw_wr_data;
    dec = hex_to_nib(rx_char);
    byte_in = {rx_nib, dec[3:0]};
    ck_rx = {ckh_b, byte_in};
    frame_ok = (cnt_b == `SRH_CMD_COUNT) && (cmd1_b == `SRH_CHAR_READ)
      && (cmd2_b == `SRH_CMD_MEM || cmd2_b == `SRH_CMD_CFG || cmd2_b == `SRH_CMD_VER)
      && (ck_rx == `SRH_CKSM_BASE - rx_sum);
    eff = {1'b0, cmd_base(cmd2_b)} + {1'b0, addr_b};
    if (mem_bus.wr_en && fw_wr_addr == `SRH_REG_NODE_BUS_ADDRESS)
    begin
      next_node_addr = fw_wr_data;
    end
    case (state)
      SRH_RX:
      begin
        if (rx_valid)
        begin
          next_idle_cnt = 32'h0;
          if (!dec[4])
          begin
            // non-hex character: frame cannot be trusted
            next_rx_idx = 4'h0;
            next_rx_hi = 1'b0;
          end
          else if (!rx_hi)
          begin
            next_rx_nib = dec[3:0];
            next_rx_hi = 1'b1;
          end
          else
          begin
            next_rx_hi = 1'b0;
            if (rx_idx < `SRH_CMD_CKSM_IDX)
            begin
              next_rx_sum = rx_sum + {8'h00, byte_in};
            end
            case (rx_idx)
              4'h0:
              begin
                next_rx_sum = {8'h00, byte_in};
              end
              4'h1: next_cnt_b = byte_in;
              4'h2: next_iaddr_b = byte_in;
              4'h3: next_cmd1_b = byte_in;
              4'h4: next_cmd2_b = byte_in;
              4'h5: next_addr_b[15:8] = byte_in;
              4'h6: next_addr_b[7:0] = byte_in;
              4'h7: next_len_b = byte_in;
              4'h8: next_ckh_b = byte_in;
              default: ;
            endcase
            if (rx_idx == 4'h0 && byte_in != `SRH_CHAR_START)
            begin
              next_rx_idx = 4'h0;
            end
            else if (rx_idx == `SRH_CMD_LAST_IDX)
            begin
              next_rx_idx = 4'h0;
              // other instruments' frames pass in silence
              if (iaddr_b == node_addr)
              begin
                next_state = SRH_LOAD;
                next_field = SRH_F_HDR;
                next_is_err = !(frame_ok && eff < MEM_DEPTH);
                next_rd_ptr = eff[MEM_AW-1:0];
                next_remain = len_b;
                next_tx_sum = 16'h0000;
                next_last = 1'b0;
              end
            end
            else
            begin
              next_rx_idx = rx_idx + 4'h1;
            end
          end
        end
        else if (rx_idx != 4'h0 || rx_hi)
        begin
          // gap inside a frame
          if (idle_cnt >= IDLE_CYCLES - 1)
          begin
            next_rx_idx = 4'h0;
            next_rx_hi = 1'b0;
            next_idle_cnt = 32'h0;
          end
          else
          begin
            next_idle_cnt = idle_cnt + 32'h1;
          end
        end
      end
      SRH_LOAD:
      begin
        next_state = SRH_HI;
        case (field)
          SRH_F_HDR:
          begin
            next_cur = is_err ? `SRH_CHAR_ERR : `SRH_CHAR_ACK;
            next_field = SRH_F_CNT;
          end
          SRH_F_CNT:
          begin
            // count covers data plus checksum
            next_cur = is_err ? `SRH_ERR_COUNT : len_b + `SRH_RESP_EXTRA;
            next_field = (is_err || remain == 8'h00) ? SRH_F_CKH : SRH_F_DATA;
          end
          SRH_F_DATA:
          begin
            mem_bus.rd_en = 1'b1;
            next_state = SRH_WAIT;
          end
          SRH_F_CKH:
          begin
            next_cur = is_err ? 8'(`SRH_ERR_CKSM >> 8) : 8'((`SRH_CKSM_BASE - tx_sum) >> 8);
            next_field = SRH_F_CKL;
          end
          default:
          begin
            next_cur = is_err ? 8'(`SRH_ERR_CKSM & 16'h00FF)
              : 8'((`SRH_CKSM_BASE - tx_sum) & 16'h00FF);
            next_last = 1'b1;
          end
        endcase
        if (field == SRH_F_HDR || field == SRH_F_CNT)
        begin
          next_tx_sum = tx_sum + {8'h00, next_cur};
        end
      end
      SRH_WAIT:
      begin
        next_cur = mem_bus.rd_data;
        next_tx_sum = tx_sum + {8'h00, mem_bus.rd_data};
        // addresses past the top of memory wrap
        next_rd_ptr = rd_ptr + MEM_AW'(1);
        next_remain = remain - 8'h01;
        next_field = (remain == 8'h01) ? SRH_F_CKH : SRH_F_DATA;
        next_state = SRH_HI;
      end
      SRH_HI:
      begin
        if (buf_in_ready)
        begin
          push = 1'b1;
          push_data = nib_to_hex(cur[7:4]);
          next_state = SRH_LO;
        end
      end
      SRH_LO:
      begin
        if (buf_in_ready)
        begin
          push = 1'b1;
          push_data = nib_to_hex(cur[3:0]);
          next_state = last ? SRH_RX : SRH_LOAD;
        end
      end
      default: next_state = SRH_RX;
    endcase
    // stays high until the buffer has drained, so no character leaves while idle
    next_busy = (next_state != SRH_RX) || next_v0;
  end

  // ==========================================
  // two-entry output buffer: a stalled receiver loses no character
  always_comb
  begin
    next_b0 = b0;
    next_b1 = b1;
    next_v0 = v0;
    next_v1 = v1;
    if (v0 && tx_ready)
    begin
      next_v0 = v1;
      next_b0 = b1;
      next_v1 = 1'b0;
    end
    if (push)
    begin
      if (!next_v0)
      begin
        next_v0 = 1'b1;
        next_b0 = push_data;
      end
      else
      begin
        next_v1 = 1'b1;
        next_b1 = push_data;
      end
    end
  end

  // ==========================================
  // registers
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      state <= SRH_RX;
      field <= SRH_F_HDR;
      rx_idx <= 4'h0;
      rx_hi <= 1'b0;
      rx_nib <= 4'h0;
      cnt_b <= 8'h00;
      iaddr_b <= 8'h00;
      cmd1_b <= 8'h00;
      cmd2_b <= 8'h00;
      addr_b <= 16'h0000;
      len_b <= 8'h00;
      ckh_b <= 8'h00;
      rx_sum <= 16'h0000;
      idle_cnt <= 32'h0;
      cur <= 8'h00;
      tx_sum <= 16'h0000;
      remain <= 8'h00;
      rd_ptr <= '0;
      is_err <= 1'b0;
      last <= 1'b0;
      node_addr <= `SRH_NODE_ADDR_RST;
      busy <= 1'b0;
      b0 <= 8'h00;
      b1 <= 8'h00;
      v0 <= 1'b0;
      v1 <= 1'b0;
    end
    else
    begin
      state <= next_state;
      field <= next_field;
      rx_idx <= next_rx_idx;
      rx_hi <= next_rx_hi;
      rx_nib <= next_rx_nib;
      cnt_b <= next_cnt_b;
      iaddr_b <= next_iaddr_b;
      cmd1_b <= next_cmd1_b;
      cmd2_b <= next_cmd2_b;
      addr_b <= next_addr_b;
      len_b <= next_len_b;
      ckh_b <= next_ckh_b;
      rx_sum <= next_rx_sum;
      idle_cnt <= next_idle_cnt;
      cur <= next_cur;
      tx_sum <= next_tx_sum;
      remain <= next_remain;
      rd_ptr <= next_rd_ptr;
      is_err <= next_is_err;
      last <= next_last;
      node_addr <= next_node_addr;
      busy <= next_busy;
      b0 <= next_b0;
      b1 <= next_b1;
      v0 <= next_v0;
      v1 <= next_v1;
    end
  end
endmodule

// ===== tb/srh_assertions.sv
// Purpose: port checks of srh_top
// Assumes: one clock, synchronous reset
// Notes: bound to the top from the bench
module srh_chk
  import srh_pkg::*;
(
  input wire logic clk,
  input wire logic reset,
  input wire logic [7:0] rx_char,
  input wire logic rx_valid,
  input wire logic [7:0] tx_char,
  input wire logic tx_valid,
  input wire logic tx_ready,
  input wire logic fw_wr_en,
  input wire logic [15:0] fw_wr_addr,
  input wire logic [7:0] fw_wr_data,
  input wire logic [7:0] own_address,
  input wire logic busy
);
  timeunit 1ns;
  timeprecision 1ps;
  // ==========================================
  // helper: first character of an answer still due
  logic busy_d;
  logic first_pend;
  logic next_busy_d;
  logic next_first_pend;
  default clocking @(posedge clk);
  endclocking
  default disable iff (reset);
  always_comb
  begin
    next_busy_d = busy;
    next_first_pend = (busy & ~busy_d) | (first_pend & ~tx_valid);
  end
  always_ff @(posedge clk)
  begin
    busy_d <= reset ? 1'b0 : next_busy_d;
    first_pend <= reset ? 1'b0 : next_first_pend;
  end
  // ==========================================
  // checks
  chk_tx_hold: assert property (tx_valid && !tx_ready |=> tx_valid && $stable(tx_char))
    else $error("tx char changed before accept");
  chk_hex_only: assert property (tx_valid |-> tx_char inside {[8'h30:8'h39], [8'h41:8'h46]})
    else $error("tx char is not upper case hex");
  chk_tx_busy: assert property (tx_valid |-> busy)
    else $error("tx char outside an answer");
  chk_addr_load: assert property (fw_wr_en && fw_wr_addr == 16'h002C |=> own_address == $past(fw_wr_data))
    else $error("own address not updated");
  chk_reset_idle: assert property ($fell(reset) |-> !tx_valid && !busy && own_address == 8'h01)
    else $error("not idle after reset");
  chk_busy_cause: assert property ($rose(busy) |-> $past(rx_valid))
    else $error("answer began without a received char");
  chk_first_soon: assert property ($rose(busy) |-> ##[1:4] tx_valid)
    else $error("answer slow to start");
  // ack and error codes both start with char 4, so one check serves both
  chk_first_char: assert property (first_pend && tx_valid |-> tx_char == 8'h34)
    else $error("answer does not start with ack or error code");
  chk_done_empty: assert property ($fell(busy) |-> !tx_valid)
    else $error("chars left after answer ended");
endmodule

// ===== tb/srh_host_model.sv
// Purpose: bus master side, takes answer chars
// Assumes: upper case hex pairs, high nibble first
// Notes: stall lets one char through in four
module srh_host_model
(
  input wire logic clk,
  input wire logic [7:0] tx_char,
  input wire logic tx_valid,
  input wire logic stall,
  output logic tx_ready
);
  timeunit 1ns;
  timeprecision 1ps;
  // ==========================================
  // char pairs to bytes
  logic [7:0] got[$];
  logic [3:0] hi = 4'h0;
  logic half = 1'b0;
  logic [1:0] cnt = 2'h0;
  function automatic logic [3:0] nib(input logic [7:0] c);
    nib = (c >= 8'h41) ? 4'(c - 8'h37) : 4'(c - 8'h30);
  endfunction
  assign tx_ready = !stall || (cnt == 2'h3);
  always @(posedge clk)
  begin
    cnt <= cnt + 2'h1;
    if (tx_valid && tx_ready)
    begin
      if (half)
        got.push_back({hi, nib(tx_char)});
      hi <= nib(tx_char);
      half <= !half;
    end
  end
endmodule

// ===== tb/srh_top_tb.sv
// Purpose: self-checking bench of srh_top
// Assumes: short idle timeout for simulation
// Notes: memory filled through the firmware port first
`include "srh_params.svh"
module srh_top_tb;
  import srh_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  // ==========================================
  // signals and instances
  localparam int IDLE = 200;
  logic clk = 1'b0;
  logic reset = 1'b1;
  logic [7:0] rx_char = 8'h00;
  logic rx_valid = 1'b0;
  logic [7:0] tx_char;
  logic tx_valid;
  logic tx_ready;
  logic fw_wr_en = 1'b0;
  logic [15:0] fw_wr_addr = 16'h0000;
  logic [7:0] fw_wr_data = 8'h00;
  logic [7:0] own_address;
  logic busy;
  logic stall = 1'b0;
  int miscompares = 0;
  int n_checks = 0;
  logic [7:0] exp_q[$];
  always #2 clk = ~clk;
  srh_top #(.MEM_AW(8), .IDLE_CYCLES(IDLE)) dut_u (.clk(clk), .reset(reset),
    .rx_char(rx_char), .rx_valid(rx_valid), .tx_char(tx_char), .tx_valid(tx_valid),
    .tx_ready(tx_ready), .fw_wr_en(fw_wr_en), .fw_wr_addr(fw_wr_addr),
    .fw_wr_data(fw_wr_data), .own_address(own_address), .busy(busy));
  srh_host_model pm_u (.clk(clk), .tx_char(tx_char), .tx_valid(tx_valid),
    .stall(stall), .tx_ready(tx_ready));
  // ==========================================
  // helpers
  function automatic logic [7:0] mem_val(input logic [7:0] a);
    mem_val = (a == 8'h2C) ? 8'h05 : a ^ 8'hA5;
  endfunction
  function automatic logic [7:0] hexc(input logic [3:0] n);
    hexc = (n < 4'hA) ? 8'h30 + 8'(n) : 8'h37 + 8'(n);
  endfunction
  function automatic logic [15:0] cks(input logic [7:0] q[$]);
    cks = 16'hFFFF;
    foreach (q[i])
      cks -= 16'(q[i]);
  endfunction
  task automatic close_out();
    $display("checks %0d mismatches %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  task automatic check(input logic [7:0] got, input logic [7:0] exp, input string what);
    n_checks++;
    if (got !== exp)
    begin
      miscompares++;
      $display("wrong value at %0t: %s got %h want %h", $time, what, got, exp);
    end
  endtask
  // rx_valid stays high across a frame so it is never set twice in one step
  task automatic send_q(input logic [7:0] q[$]);
    foreach (q[i])
    begin
      rx_char <= q[i];
      rx_valid <= 1'b1;
      @(posedge clk);
    end
    rx_valid <= 1'b0;
    @(posedge clk);
  endtask
  task automatic send_cmd(input logic [7:0] a, input logic [7:0] cmd, input logic [15:0] st,
                          input logic [7:0] len, input logic [15:0] ckx);
    logic [7:0] b[$];
    logic [7:0] c[$];
    logic [15:0] s;
    b = '{8'h21, 8'h09, a, 8'h52, cmd, st[15:8], st[7:0], len};
    s = cks(b) ^ ckx;
    b.push_back(s[15:8]);
    b.push_back(s[7:0]);
    foreach (b[i])
    begin
      c.push_back(hexc(b[i][7:4]));
      c.push_back(hexc(b[i][3:0]));
    end
    pm_u.got.delete();
    send_q(c);
  endtask
  task automatic run(input logic [7:0] cmd, input logic [15:0] st, input logic [7:0] len,
                     input logic [15:0] ckx, input logic err, input string what);
    logic [15:0] s;
    logic [15:0] from;
    int n;
    from = (cmd == `SRH_CMD_CFG) ? `SRH_CFG_BASE : 16'h0000;
    from = (cmd == `SRH_CMD_VER) ? `SRH_VER_BASE : from;
    if (err)
      exp_q = '{8'h45, 8'h02};
    else
      exp_q = '{8'h41, 8'(len + 8'h02)};
    for (int i = 0; !err && i < 32'(len); i++)
      exp_q.push_back(mem_val(8'(from + st + 16'(i))));
    s = err ? `SRH_ERR_CKSM : cks(exp_q);
    exp_q.push_back(s[15:8]);
    exp_q.push_back(s[7:0]);
    send_cmd(8'h05, cmd, st, len, ckx);
    // busy rises the edge after the last char; let it land before polling
    repeat (2) @(posedge clk);
    n = 0;
    while ((pm_u.got.size() < exp_q.size() || busy !== 1'b0) && n < 3000)
    begin
      @(posedge clk);
      n++;
    end
    if (n >= 3000)
    begin
      miscompares++;
      $display("wrong value at %0t: %s hung", $time, what);
      close_out();
    end
    check(8'(pm_u.got.size()), 8'(exp_q.size()), what);
    foreach (exp_q[i])
      check(pm_u.got[i], exp_q[i], what);
    $display("test %s done", what);
  endtask
  // ==========================================
  // sequence
  initial
  begin
    repeat (8) @(posedge clk);
    reset <= 1'b0;
    @(posedge clk);
    for (int i = 0; i < 256; i++)
    begin
      fw_wr_en <= 1'b1;
      fw_wr_addr <= 16'(i);
      fw_wr_data <= mem_val(8'(i));
      @(posedge clk);
    end
    fw_wr_en <= 1'b0;
    run(`SRH_CMD_MEM, 16'h0000, 8'h03, 16'h0000, 1'b0, "mem");
    run(`SRH_CMD_MEM, 16'h00FE, 8'h04, 16'h0000, 1'b0, "mem wrap");
    run(`SRH_CMD_MEM, 16'h0010, 8'h00, 16'h0000, 1'b0, "mem len 0");
    run(`SRH_CMD_CFG, 16'h0001, 8'h02, 16'h0000, 1'b0, "cfg");
    run(`SRH_CMD_VER, 16'h0000, 8'h04, 16'h0000, 1'b0, "ver");
    run(`SRH_CMD_MEM, 16'h0020, 8'h02, 16'h0001, 1'b1, "bad sum");
    run(`SRH_CMD_MEM, 16'h0100, 8'h01, 16'h0000, 1'b1, "out of range");
    run(8'h72, 16'h0000, 8'h01, 16'h0000, 1'b1, "bad cmd");
    stall <= 1'b1;
    run(`SRH_CMD_MEM, 16'h0040, 8'h08, 16'h0000, 1'b0, "stall");
    stall <= 1'b0;
    send_q('{8'h32, 8'h31, 8'h30});
    repeat (IDLE + 50) @(posedge clk);
    run(`SRH_CMD_MEM, 16'h0030, 8'h02, 16'h0000, 1'b0, "gap");
    send_q('{8'h32, 8'h47});
    run(`SRH_CMD_MEM, 16'h0050, 8'h01, 16'h0000, 1'b0, "junk");
    send_cmd(8'h06, `SRH_CMD_MEM, 16'h0000, 8'h02, 16'h0000);
    repeat (100) @(posedge clk);
    check(8'(pm_u.got.size()), 8'h00, "other address");
    $display("test other address done");
    close_out();
  end
endmodule
bind srh_top srh_chk chk_u (.clk(clk), .reset(reset), .rx_char(rx_char),
  .rx_valid(rx_valid), .tx_char(tx_char), .tx_valid(tx_valid), .tx_ready(tx_ready),
  .fw_wr_en(fw_wr_en), .fw_wr_addr(fw_wr_addr), .fw_wr_data(fw_wr_data),
  .own_address(own_address), .busy(busy));
